// [adp_regs.sv]
// Function
// [RULE_01] hp_filter_skip bit 7 set routes audio around the high-pass filter.
// [RULE_02] digital_gain_lift codes 00..11 add 0, 6, 12, 18 dB; reset 01.
// [RULE_03] rate_speed_select clear selects single speed: 32, 44.1, 48 kHz.
// [RULE_04] rate_speed_select set selects double speed: 88.2, 96 kHz.
// [RULE_05] format codes 000..011 select right justified 24, 20, 18, 16 bits.
// [RULE_06] format code 100, the reset value, selects standard I2S framing.
// [RULE_07] format code 101 selects left justified, 16 to 24 bits.
// [RULE_08] software never writes format codes above 101.
// [RULE_09] volume config bit 7, reset 1, enables volume fading.
// [RULE_10] right_silence bit 1 soft-mutes right; outputs go to 50/50 duty.
// [RULE_11] left_silence bit 0 soft-mutes left the same way.
// [RULE_12] reserved bits read zero and software leaves them at default.
// [RULE_13] volume codes step 0.5 dB, all ones giving +24 dB.
// [RULE_14] code 11001111 is 0 dB and both volumes reset to it.
// [RULE_15] code 00000111 is the lowest audible level, -100 dB.
// [RULE_16] volume codes below 00000111 mute the channel.
// [RULE_17] left and right volumes sit at 0x04, 0x05, applied independently.
// [RULE_18] double speed halves the pwm switching rate.
// [RULE_19] with fade on, gain changes ramp in 0.5 dB steps at fixed interval.
// [RULE_20] channel mutes when mute bit set or volume code in mute region.
module adp_regs (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic rd_valid,
	output logic hp_filter_skip,
	output logic [1:0] digital_gain_lift,
	output logic rate_speed_select,
	output logic [4:0] rx_word_bits,
	output logic rx_i2s,
	output logic rx_left_just,
	output logic [1:0] pwm_rate_div,
	output logic [7:0] left_gain_code,
	output logic [7:0] right_gain_code,
	output logic left_silent,
	output logic right_silent,
	output logic left_duty_half,
	output logic right_duty_half
);
	// ******************************
	// register file
	// ******************************
	logic [7:0] dig_ctrl_reg;
	logic [7:0] vol_cfg_reg;
	logic [7:0] vol_left_reg;
	logic [7:0] vol_right_reg;
	logic [7:0] rdata_reg;
	logic rd_valid_reg;

	// mask enforces read-only zero on reserved bits
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			dig_ctrl_reg <= adp_pkg::DIG_CTRL_RST;
		end else if (clk_en && wr_en && addr == adp_pkg::ADDR_DIG_CTRL) begin
			dig_ctrl_reg <= wdata & adp_pkg::DIG_CTRL_WMASK; // [RULE_12]
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			vol_cfg_reg <= adp_pkg::VOL_CFG_RST;
		end else if (clk_en && wr_en && addr == adp_pkg::ADDR_VOL_CFG) begin
			vol_cfg_reg <= wdata & adp_pkg::VOL_CFG_WMASK; // [RULE_12]
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			vol_left_reg <= adp_pkg::VOL_RST; // [RULE_14]
			vol_right_reg <= adp_pkg::VOL_RST; // [RULE_14]
		end else if (clk_en && wr_en) begin
			if (addr == adp_pkg::ADDR_VOL_LEFT) begin
				vol_left_reg <= wdata; // [RULE_17]
			end
			if (addr == adp_pkg::ADDR_VOL_RIGHT) begin
				vol_right_reg <= wdata; // [RULE_17]
			end
		end
	end

	// unmapped addresses read zero
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rdata_reg <= 8'h00;
			rd_valid_reg <= 1'b0;
		end else if (clk_en) begin
			rd_valid_reg <= rd_en;
			if (rd_en) begin
				case (addr)
					adp_pkg::ADDR_DIG_CTRL: rdata_reg <= dig_ctrl_reg;
					adp_pkg::ADDR_VOL_CFG: rdata_reg <= vol_cfg_reg;
					adp_pkg::ADDR_VOL_LEFT: rdata_reg <= vol_left_reg;
					adp_pkg::ADDR_VOL_RIGHT: rdata_reg <= vol_right_reg;
					default: rdata_reg <= 8'h00;
				endcase
			end
		end
	end

	// ******************************
	// fade timing
	// ******************************
	localparam int TW = $clog2(adp_pkg::FADE_STEP_CYC);
	localparam logic [TW-1:0] TICK_LAST = TW'(adp_pkg::FADE_STEP_CYC - 1);
	logic [TW-1:0] tick_cnt_reg;
	logic step_tick;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			tick_cnt_reg <= '0;
		end else if (clk_en) begin
			if (tick_cnt_reg == TICK_LAST) begin
				tick_cnt_reg <= '0;
			end else begin
				tick_cnt_reg <= tick_cnt_reg + TW'(1);
			end
		end
	end
	assign step_tick = (tick_cnt_reg == TICK_LAST); // [RULE_19]

	function automatic logic in_mute_zone(input logic [7:0] code);
		in_mute_zone = code < adp_pkg::VOL_MUTE_BELOW; // [RULE_16]
	endfunction : in_mute_zone

	function automatic logic [7:0] fade_target(input logic [7:0] code,
			input logic mute_bit);
		// with fade on, muting ramps down to zero code; with fade off it cuts at once
		if (mute_bit || in_mute_zone(code)) begin // [RULE_20]
			fade_target = 8'h00;
		end else begin
			fade_target = code; // [RULE_13] [RULE_15]
		end
	endfunction : fade_target

	logic fade_on;
	logic [7:0] left_target;
	logic [7:0] right_target;
	logic [7:0] left_level;
	logic [7:0] right_level;

	assign fade_on = vol_cfg_reg[adp_pkg::FADE_BIT]; // [RULE_09]
	assign left_target = fade_target(vol_left_reg,
		vol_cfg_reg[adp_pkg::SIL_L_BIT]);
	assign right_target = fade_target(vol_right_reg,
		vol_cfg_reg[adp_pkg::SIL_R_BIT]);

	adp_fader u_fade_left (
		.clock(clock),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.step_tick(step_tick),
		.fade_on(fade_on),
		.target(left_target),
		.level(left_level)
	);

	adp_fader u_fade_right (
		.clock(clock),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.step_tick(step_tick),
		.fade_on(fade_on),
		.target(right_target),
		.level(right_level)
	);

	// ******************************
	// decoded outputs
	// ******************************
	logic hp_skip_reg;
	logic [1:0] gain_reg;
	logic speed_reg;
	logic [4:0] word_bits_reg;
	logic i2s_reg;
	logic lj_reg;
	logic [1:0] pwm_div_reg;
	logic [7:0] left_code_reg;
	logic [7:0] right_code_reg;
	logic left_sil_reg;
	logic right_sil_reg;
	logic left_duty_reg;
	logic right_duty_reg;
	logic [2:0] fmt;

	assign fmt = dig_ctrl_reg[adp_pkg::FMT_LSB +: 3];

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			hp_skip_reg <= 1'b0;
			gain_reg <= adp_pkg::DIG_CTRL_RST[adp_pkg::GAIN_LSB +: 2];
			speed_reg <= 1'b0;
			pwm_div_reg <= adp_pkg::PWM_DIV_SINGLE;
		end else if (clk_en) begin
			hp_skip_reg <= dig_ctrl_reg[adp_pkg::HPF_SKIP_BIT]; // [RULE_01]
			gain_reg <= dig_ctrl_reg[adp_pkg::GAIN_LSB +: 2]; // [RULE_02]
			speed_reg <= dig_ctrl_reg[adp_pkg::SPEED_BIT]; // [RULE_03] [RULE_04]
			pwm_div_reg <= dig_ctrl_reg[adp_pkg::SPEED_BIT] ?
				adp_pkg::PWM_DIV_DOUBLE : adp_pkg::PWM_DIV_SINGLE; // [RULE_18]
		end
	end

	// reserved format codes fall back to i2s; software must avoid them
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			word_bits_reg <= 5'h18;
			i2s_reg <= 1'b1;
			lj_reg <= 1'b0;
		end else if (clk_en) begin
			i2s_reg <= 1'b0;
			lj_reg <= 1'b0;
			word_bits_reg <= 5'h18;
			case (fmt)
				adp_pkg::FMT_RJ24: word_bits_reg <= 5'h18; // [RULE_05]
				adp_pkg::FMT_RJ20: word_bits_reg <= 5'h14; // [RULE_05]
				adp_pkg::FMT_RJ18: word_bits_reg <= 5'h12; // [RULE_05]
				adp_pkg::FMT_RJ16: word_bits_reg <= 5'h10; // [RULE_05]
				adp_pkg::FMT_I2S: i2s_reg <= 1'b1; // [RULE_06]
				adp_pkg::FMT_LJ: lj_reg <= 1'b1; // [RULE_07]
				default: i2s_reg <= 1'b1; // [RULE_08]
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			left_code_reg <= adp_pkg::VOL_UNITY;
			right_code_reg <= adp_pkg::VOL_UNITY;
			left_sil_reg <= 1'b0;
			right_sil_reg <= 1'b0;
			left_duty_reg <= 1'b0;
			right_duty_reg <= 1'b0;
		end else if (clk_en) begin
			left_code_reg <= left_level; // [RULE_17]
			right_code_reg <= right_level; // [RULE_17]
			left_sil_reg <= in_mute_zone(left_level); // [RULE_16]
			right_sil_reg <= in_mute_zone(right_level); // [RULE_16]
			left_duty_reg <= vol_cfg_reg[adp_pkg::SIL_L_BIT]; // [RULE_11]
			right_duty_reg <= vol_cfg_reg[adp_pkg::SIL_R_BIT]; // [RULE_10]
		end
	end

	assign rdata = rdata_reg;
	assign rd_valid = rd_valid_reg;
	assign hp_filter_skip = hp_skip_reg;
	assign digital_gain_lift = gain_reg;
	assign rate_speed_select = speed_reg;
	assign rx_word_bits = word_bits_reg;
	assign rx_i2s = i2s_reg;
	assign rx_left_just = lj_reg;
	assign pwm_rate_div = pwm_div_reg;
	assign left_gain_code = left_code_reg;
	assign right_gain_code = right_code_reg;
	assign left_silent = left_sil_reg;
	assign right_silent = right_sil_reg;
	assign left_duty_half = left_duty_reg;
	assign right_duty_half = right_duty_reg;

	// ******************************
	// checks
	// ******************************
	// two enabled edges: one into the fader, one into the output stage
	sequence s_left_zone_held;
		clk_en && !fade_on &&
		vol_left_reg < adp_pkg::VOL_MUTE_BELOW ##1 clk_en;
	endsequence
	sequence s_right_mute_held;
		clk_en && !fade_on &&
		vol_cfg_reg[adp_pkg::SIL_R_BIT] ##1 clk_en;
	endsequence
	sequence s_right_plain_held;
		clk_en && !fade_on && !vol_cfg_reg[adp_pkg::SIL_R_BIT] &&
		vol_right_reg >= adp_pkg::VOL_MUTE_BELOW ##1 clk_en;
	endsequence

	a_rsvd_dig_zero: assert property (@(posedge clock) // [RULE_12]
		disable iff (!reset_n) !dig_ctrl_reg[adp_pkg::DIG_RSVD_BIT])
		else $error("reserved digital bit set");
	a_rsvd_cfg_zero: assert property (@(posedge clock) // [RULE_12]
		disable iff (!reset_n) vol_cfg_reg[6:2] == 5'h00)
		else $error("reserved volume config bits set");
	a_hpf_follow: assert property (@(posedge clock) // [RULE_01]
		disable iff (!reset_n)
		clk_en |=> hp_filter_skip ==
		$past(dig_ctrl_reg[adp_pkg::HPF_SKIP_BIT]))
		else $error("filter skip not following register");
	a_gain_follow: assert property (@(posedge clock) // [RULE_02]
		disable iff (!reset_n)
		clk_en |=> digital_gain_lift ==
		$past(dig_ctrl_reg[adp_pkg::GAIN_LSB +: 2]))
		else $error("gain lift not following register");
	a_speed_follow: assert property (@(posedge clock) // [RULE_03] [RULE_04]
		disable iff (!reset_n)
		clk_en |=> rate_speed_select ==
		$past(dig_ctrl_reg[adp_pkg::SPEED_BIT]))
		else $error("speed select not following register");
	a_pwm_half: assert property (@(posedge clock) // [RULE_18]
		disable iff (!reset_n)
		clk_en && dig_ctrl_reg[adp_pkg::SPEED_BIT] |=>
		pwm_rate_div == adp_pkg::PWM_DIV_DOUBLE)
		else $error("pwm rate not halved");
	a_pwm_single: assert property (@(posedge clock) // [RULE_18]
		disable iff (!reset_n)
		clk_en && !dig_ctrl_reg[adp_pkg::SPEED_BIT] |=>
		pwm_rate_div == adp_pkg::PWM_DIV_SINGLE)
		else $error("pwm rate not single speed");
	a_fmt_i2s: assert property (@(posedge clock) // [RULE_06]
		disable iff (!reset_n)
		clk_en && fmt == adp_pkg::FMT_I2S |=> rx_i2s && !rx_left_just)
		else $error("i2s format not selected");
	a_fmt_rj16: assert property (@(posedge clock) // [RULE_05]
		disable iff (!reset_n)
		clk_en && fmt == adp_pkg::FMT_RJ16 |=>
		rx_word_bits == 5'h10 && !rx_i2s)
		else $error("rj16 word length wrong");
	a_fmt_rj24: assert property (@(posedge clock) // [RULE_05]
		disable iff (!reset_n)
		clk_en && fmt == adp_pkg::FMT_RJ24 |=>
		rx_word_bits == 5'h18 && !rx_i2s && !rx_left_just)
		else $error("rj24 word length wrong");
	a_fmt_lj: assert property (@(posedge clock) // [RULE_07]
		disable iff (!reset_n)
		clk_en && fmt == adp_pkg::FMT_LJ |=> rx_left_just && !rx_i2s)
		else $error("left justified not selected");
	a_mute_duty: assert property (@(posedge clock) // [RULE_11]
		disable iff (!reset_n)
		clk_en |=> left_duty_half == $past(vol_cfg_reg[adp_pkg::SIL_L_BIT]))
		else $error("left mute duty not following");
	a_right_duty: assert property (@(posedge clock) // [RULE_10]
		disable iff (!reset_n)
		clk_en |=> right_duty_half == $past(vol_cfg_reg[adp_pkg::SIL_R_BIT]))
		else $error("right mute duty not following");
	a_mute_zone: assert property (@(posedge clock) // [RULE_16]
		disable iff (!reset_n) s_left_zone_held |=> left_silent)
		else $error("mute region not muting");
	a_mute_bit: assert property (@(posedge clock) // [RULE_20]
		disable iff (!reset_n) s_right_mute_held |=> right_silent)
		else $error("mute bit not silencing");
	a_nofade_jump: assert property (@(posedge clock) // [RULE_09]
		disable iff (!reset_n)
		s_right_plain_held |=> right_gain_code == $past(vol_right_reg, 2))
		else $error("volume not applied without fade");
	a_fade_step: assert property (@(posedge clock) // [RULE_19]
		disable iff (!reset_n)
		clk_en && fade_on |=> (left_level == $past(left_level) ||
		left_level == $past(left_level) + 8'h01 ||
		left_level == $past(left_level) - 8'h01))
		else $error("fade stepped more than one code");
	a_fade_hold: assert property (@(posedge clock) // [RULE_19]
		disable iff (!reset_n)
		clk_en && fade_on && !step_tick |=> $stable(right_level))
		else $error("fade moved between steps");
	a_vol_reset: assert property (@(posedge clock) // [RULE_14]
		!reset_n |=> vol_left_reg == adp_pkg::VOL_RST &&
		vol_right_reg == adp_pkg::VOL_RST)
		else $error("volume reset value wrong");
endmodule : adp_regs

// [adp_pkg.sv]
package adp_pkg;
	// ******************************
	// register map
	// ******************************
	localparam logic [7:0] ADDR_DIG_CTRL = 8'h02;
	localparam logic [7:0] ADDR_VOL_CFG = 8'h03;
	localparam logic [7:0] ADDR_VOL_LEFT = 8'h04;
	localparam logic [7:0] ADDR_VOL_RIGHT = 8'h05;

	// ******************************
	// field positions
	// ******************************
	localparam int HPF_SKIP_BIT = 7;
	localparam int DIG_RSVD_BIT = 6;
	localparam int GAIN_LSB = 4;
	localparam int SPEED_BIT = 3;
	localparam int FMT_LSB = 0;
	localparam int FADE_BIT = 7;
	localparam int SIL_R_BIT = 1;
	localparam int SIL_L_BIT = 0;

	// ******************************
	// reset values and write masks
	// ******************************
	localparam logic [7:0] DIG_CTRL_RST = 8'h14;
	localparam logic [7:0] VOL_CFG_RST = 8'h80;
	localparam logic [7:0] VOL_RST = 8'hCF;
	localparam logic [7:0] DIG_CTRL_WMASK = 8'hBF;
	localparam logic [7:0] VOL_CFG_WMASK = 8'h83;

	// ******************************
	// volume codes
	// ******************************
	localparam logic [7:0] VOL_MUTE_BELOW = 8'h07;
	localparam logic [7:0] VOL_UNITY = 8'hCF;

	// ******************************
	// timing
	// ******************************
	localparam int CLK_MHZ = 250;
	localparam int FADE_STEP_US = 4;
	localparam int FADE_STEP_CYC = FADE_STEP_US * CLK_MHZ;
	localparam logic [1:0] PWM_DIV_SINGLE = 2'h1;
	localparam logic [1:0] PWM_DIV_DOUBLE = 2'h2;

	typedef enum logic [2:0] {
		FMT_RJ24 = 3'b000,
		FMT_RJ20 = 3'b001,
		FMT_RJ18 = 3'b010,
		FMT_RJ16 = 3'b011,
		FMT_I2S = 3'b100,
		FMT_LJ = 3'b101
	} adp_fmt_t;
endpackage : adp_pkg

// [adp_fader.sv]
module adp_fader (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic step_tick,
	input wire logic fade_on,
	input wire logic [7:0] target,
	output logic [7:0] level
);
	// ******************************
	// gain ramp, one 0.5 db code per tick
	// ******************************
	logic [7:0] level_reg;
	logic [7:0] level_next;

	always_comb begin
		level_next = level_reg;
		if (!fade_on) begin
			level_next = target;
		end else if (step_tick && level_reg < target) begin
			level_next = level_reg + 8'h01; // [RULE_19]
		end else if (step_tick && level_reg > target) begin
			level_next = level_reg - 8'h01; // [RULE_19]
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			level_reg <= adp_pkg::VOL_RST;
		end else if (clk_en) begin
			level_reg <= level_next;
		end
	end

	assign level = level_reg;
endmodule : adp_fader

// [adp_regs_tb_top.sv]
module adp_regs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ******************************
	// stimulus and observed signals
	// ******************************
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata, lg, rg;
	logic rd_valid, hp, spd, li2s, llj, ls, rs, ld, rdh;
	logic [1:0] gl, pwm;
	logic [4:0] wb;
	int n_errors = 0;
	int n_compared = 0;
	always #2 clock = ~clock;

	adp_regs adp_regs_i (
		.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
		.wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
		.rdata(rdata), .rd_valid(rd_valid), .hp_filter_skip(hp),
		.digital_gain_lift(gl), .rate_speed_select(spd),
		.rx_word_bits(wb), .rx_i2s(li2s), .rx_left_just(llj),
		.pwm_rate_div(pwm), .left_gain_code(lg), .right_gain_code(rg),
		.left_silent(ls), .right_silent(rs),
		.left_duty_half(ld), .right_duty_half(rdh)
	);

	// ******************************
	// shared tasks
	// ******************************
	task automatic stop_test();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [7:0] s,
			input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask : chk

	// inputs always move 1 ns after the rising edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		addr = a;
		wdata = v;
		wr_en = 1'b1;
		cyc(1);
		wr_en = 1'b0;
		cyc(1);
	endtask : wr

	// the answer stands exactly one edge after the strobe; an idle edge
	// follows so the next strobe is never raised as this one drops
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		rd_en = 1'b1;
		cyc(1);
		rd_en = 1'b0;
		chk("rd_valid", {7'h00, rd_valid}, 8'h01);
		chk("rdata", rdata, e);
		cyc(1);
	endtask : rchk

	// ******************************
	// scenarios
	// ******************************
	task automatic t_reset();
		rchk(adp_pkg::ADDR_DIG_CTRL, 8'h14);
		rchk(adp_pkg::ADDR_VOL_CFG, 8'h80);
		rchk(adp_pkg::ADDR_VOL_LEFT, 8'hCF);
		rchk(adp_pkg::ADDR_VOL_RIGHT, 8'hCF);
		rchk(8'h06, 8'h00);
		chk("gain", {6'h00, gl}, 8'h01);
		chk("i2s", {7'h00, li2s}, 8'h01);
		chk("lgain", lg, 8'hCF);
	endtask : t_reset

	// every legal format code, gain code and speed; reserved bit kept zero
	task automatic t_digital();
		logic [4:0] wbits [4];
		logic [7:0] v;
		wbits = '{5'h18, 5'h14, 5'h12, 5'h10};
		for (int f = 0; f < 6; f++) begin
			v = {f[1], 1'b0, f[1:0], f[0], f[2:0]};
			wr(adp_pkg::ADDR_DIG_CTRL, v);
			cyc(3);
			rchk(adp_pkg::ADDR_DIG_CTRL, v & 8'hBF);
			chk("hp", {7'h00, hp}, {7'h00, f[1]});
			chk("gain", {6'h00, gl}, {6'h00, f[1:0]});
			chk("speed", {7'h00, spd}, {7'h00, f[0]});
			chk("pwm", {6'h00, pwm}, f[0] ? 8'h02 : 8'h01);
			chk("bits", {3'h0, wb}, {3'h0, f < 4 ? wbits[f] : 5'h18});
			chk("i2s", {7'h00, li2s}, {7'h00, f == 4});
			chk("lj", {7'h00, llj}, {7'h00, f == 5});
		end
	endtask : t_digital

	task automatic t_mute();
		wr(adp_pkg::ADDR_VOL_CFG, 8'h02);
		cyc(4);
		rchk(adp_pkg::ADDR_VOL_CFG, 8'h02);
		chk("rduty", {7'h00, rdh}, 8'h01);
		chk("lduty", {7'h00, ld}, 8'h00);
		chk("rsil", {7'h00, rs}, 8'h01);
		chk("lgain", lg, 8'hCF);
		wr(adp_pkg::ADDR_VOL_CFG, 8'h01);
		cyc(4);
		chk("lduty", {7'h00, ld}, 8'h01);
		chk("rsil", {7'h00, rs}, 8'h00);
		chk("lgain", lg, 8'h00);
		wr(adp_pkg::ADDR_VOL_CFG, 8'h00);
	endtask : t_mute

	task automatic t_volume();
		wr(adp_pkg::ADDR_VOL_LEFT, 8'h06);
		wr(adp_pkg::ADDR_VOL_RIGHT, 8'hFF);
		cyc(4);
		chk("lsil", {7'h00, ls}, 8'h01);
		chk("rsil", {7'h00, rs}, 8'h00);
		chk("rgain", rg, 8'hFF);
		rchk(adp_pkg::ADDR_VOL_RIGHT, 8'hFF);
		wr(adp_pkg::ADDR_VOL_LEFT, 8'h07);
		cyc(4);
		chk("lsil", {7'h00, ls}, 8'h00);
		chk("lgain", lg, 8'h07);
		// a write while the clock enable is low must leave no trace
		clk_en = 1'b0;
		wr(adp_pkg::ADDR_VOL_LEFT, 8'h55);
		clk_en = 1'b1;
		rchk(adp_pkg::ADDR_VOL_LEFT, 8'h07);
	endtask : t_volume

	// step phase is free running, so judge before and after two steps
	task automatic t_fade();
		wr(adp_pkg::ADDR_VOL_RIGHT, 8'hCF);
		wr(adp_pkg::ADDR_VOL_CFG, 8'h80);
		cyc(4);
		wr(adp_pkg::ADDR_VOL_RIGHT, 8'hCD);
		cyc(10);
		chk("ramp", {7'h00, rg == 8'hCD}, 8'h00);
		cyc(2100);
		chk("rgain", rg, 8'hCD);
	endtask : t_fade

	initial begin
		cyc(3);
		reset_n = 1'b1;
		t_reset();
		t_digital();
		t_mute();
		t_volume();
		t_fade();
		stop_test();
	end

	// whole run is a few thousand cycles; this leaves a wide margin
	initial begin
		#200000;
		n_errors++;
		stop_test();
	end
endmodule : adp_regs_tb_top
